// ### tppt_defines.svh
// Offsets, fields, reset values and timing counts of the preamble and port timing block
`ifndef TPPT_DEFINES_SVH
`define TPPT_DEFINES_SVH
`define TPPT_ADR_ETC2      4'h0
`define TPPT_ADR_CTRL      4'h4
`define TPPT_ADR_STAT      4'h8
`define TPPT_ADR_RES       4'hC
`define TPPT_ETC2_RST      16'h0000
`define TPPT_PRE_MSB       4
`define TPPT_PRE_LSB       2
`define TPPT_PCT_MSB       1
`define TPPT_PCT_LSB       0
`define TPPT_CTRL_START    0
`define TPPT_TST_MSB       2
`define TPPT_TST_LSB       1
`define TPPT_CLK_MHZ       20
`define TPPT_UNIT_US       128
`define TPPT_UNIT_CYC      (`TPPT_UNIT_US * `TPPT_CLK_MHZ)
`endif

// ### tppt_pkg.sv
// Types of the preamble and port timing block
package tppt_pkg;
   typedef enum logic [1:0] {
      TPPT_IDLE = 2'b00,
      TPPT_RUN  = 2'b01,
      TPPT_WAIT = 2'b11
   } tppt_state_e;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [3:0]  adr;
      logic [31:0] dat;
   } tppt_wb_req_s;
endpackage : tppt_pkg

// ### tppt_timing.sv
// Preamble and port cycle timing sequencer with its Wishbone register slave
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tppt_defines.svh"
module tppt_timing #(
   parameter logic [15:0] UNIT_CYC = 16'(`TPPT_UNIT_CYC)
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire tppt_pkg::tppt_wb_req_s wb_req_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic                  port_done_i,
   output logic                       port_start_o,
   output logic                       dummy_o,
   output logic                       timeout_o,
   output logic                       result_valid_o
);
   import tppt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [17:0] port_limit(input logic [1:0] sel);
      port_limit = 18'({16'h0000, sel} + 18'h00001) * 18'(UNIT_CYC);
   endfunction : port_limit

   logic [15:0]  etc2_r;
   logic [1:0]   tst_r;
   logic         start_r;
   tppt_state_e  state_r;
   logic [17:0]  cnt_r;
   logic [2:0]   pre_r;
   logic [1:0]   port_r;
   logic [15:0]  res_r;
   logic [1:0]   sync_r;
   logic         done_d_r;
   logic         done_ev;
   logic         wb_hit;
   logic [17:0]  limit;
   logic         slot_end;
   logic         seq_end;

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, ack held for one cycle only
   assign wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         etc2_r <= `TPPT_ETC2_RST;
         tst_r  <= 2'h0;
      end else if (wb_hit && wb_req_i.we) begin
         if (wb_req_i.adr == `TPPT_ADR_ETC2) begin
            if (wb_req_i.sel[0]) etc2_r[7:0] <= wb_req_i.dat[7:0];
            if (wb_req_i.sel[1]) etc2_r[15:8] <= wb_req_i.dat[15:8];
         end
         if (wb_req_i.adr == `TPPT_ADR_CTRL && wb_req_i.sel[0]) begin
            tst_r <= wb_req_i.dat[`TPPT_TST_MSB:`TPPT_TST_LSB];
         end
      end
   end

   // Start is a one-cycle pulse; a start while busy is ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_r <= 1'b0;
      end else begin
         start_r <= wb_hit & wb_req_i.we & wb_req_i.sel[0] & (wb_req_i.adr == `TPPT_ADR_CTRL)
                    & wb_req_i.dat[`TPPT_CTRL_START] & (state_r == TPPT_IDLE);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_hit && !wb_req_i.we) begin
         case (wb_req_i.adr)
            `TPPT_ADR_ETC2: wb_dat_o <= {16'h0000, etc2_r};
            `TPPT_ADR_CTRL: wb_dat_o <= {29'h0000_0000, tst_r, 1'b0};
            `TPPT_ADR_STAT: wb_dat_o <= {24'h00_0000, port_r, pre_r, dummy_o, state_r};
            `TPPT_ADR_RES:  wb_dat_o <= {16'h0000, res_r};
            default:        wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Done pin crosses in from the analog side; the edge is taken after the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_r   <= 2'b00;
         done_d_r <= 1'b0;
      end else begin
         sync_r   <= {sync_r[0], port_done_i};
         done_d_r <= sync_r[1];
      end
   end
   assign done_ev = sync_r[1] & ~done_d_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign limit    = port_limit(etc2_r[`TPPT_PCT_MSB:`TPPT_PCT_LSB]);
   assign slot_end = (state_r != TPPT_IDLE) && (cnt_r == limit - 18'h00001);
   assign seq_end  = slot_end && (port_r == tst_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r      <= TPPT_IDLE;
         cnt_r        <= 18'h00000;
         pre_r        <= 3'h0;
         port_r       <= 2'h0;
         dummy_o      <= 1'b0;
         port_start_o <= 1'b0;
      end else begin
         port_start_o <= 1'b0;
         case (state_r)
            TPPT_IDLE: begin
               cnt_r  <= 18'h00000;
               port_r <= 2'h0;
               if (start_r) begin
                  pre_r        <= etc2_r[`TPPT_PRE_MSB:`TPPT_PRE_LSB];
                  dummy_o      <= etc2_r[`TPPT_PRE_MSB:`TPPT_PRE_LSB] != 3'h0;
                  port_start_o <= 1'b1;
                  state_r      <= TPPT_RUN;
               end
            end
            TPPT_RUN, TPPT_WAIT: begin
               cnt_r <= cnt_r + 18'h00001;
               if (state_r == TPPT_RUN && done_ev) begin
                  state_r <= TPPT_WAIT;
               end
               if (seq_end) begin
                  cnt_r  <= 18'h00000;
                  port_r <= 2'h0;
                  if (pre_r != 3'h0) begin
                     pre_r        <= pre_r - 3'h1;
                     dummy_o      <= pre_r != 3'h1;
                     port_start_o <= 1'b1;
                     state_r      <= TPPT_RUN;
                  end else begin
                     dummy_o <= 1'b0;
                     state_r <= TPPT_IDLE;
                  end
               end else if (slot_end) begin
                  // Next start counts from the previous start, not from the done edge
                  cnt_r        <= 18'h00000;
                  port_r       <= port_r + 2'h1;
                  port_start_o <= 1'b1;
                  state_r      <= TPPT_RUN;
               end
            end
            default: state_r <= TPPT_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timeout_o <= 1'b0;
      end else begin
         timeout_o <= slot_end && (state_r == TPPT_RUN) && !done_ev;
      end
   end

   // Dummy results are dropped here so averaging downstream never sees them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_r          <= 16'h0000;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= 1'b0;
         if (state_r == TPPT_RUN && done_ev && !dummy_o) begin
            res_r          <= cnt_r[15:0];
            result_valid_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The slot counter is zero while the start pulse stands, and the pulse has dropped one edge later
   a_start_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      port_start_o && state_r != TPPT_IDLE |-> (cnt_r == 18'h00000) ##1 !port_start_o)
      else $error("port start not spaced from previous start");
   a_slot_restart: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_end && !seq_end |=> port_start_o && cnt_r == 18'h00000 && state_r == TPPT_RUN)
      else $error("next port did not start at slot end");
   a_seq_finish: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_end && pre_r == 3'h0 |=> state_r == TPPT_IDLE && !port_start_o)
      else $error("real sequence not followed by idle");
   a_period_limit: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != TPPT_IDLE |-> cnt_r < limit)
      else $error("port slot ran past its cycle time");
   a_timeout_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      timeout_o |-> $past(slot_end) && $past(state_r) == TPPT_RUN)
      else $error("timeout outside slot end");
   a_dummy_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      result_valid_o |-> !$past(dummy_o))
      else $error("dummy result reported");
   a_preamble_load: assert property (@(posedge clk_i) disable iff (rst_i)
      start_r |=> pre_r == $past(etc2_r[`TPPT_PRE_MSB:`TPPT_PRE_LSB]))
      else $error("preamble count not loaded");
   a_seq_ports: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != TPPT_IDLE |-> port_r <= tst_r)
      else $error("sequence ran more ports than configured");
   a_dummy_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != TPPT_IDLE && pre_r == 3'h0 |-> !dummy_o)
      else $error("dummy flag set in real sequence");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   c_preamble_run: cover property (@(posedge clk_i) disable iff (rst_i) seq_end && dummy_o);
   c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) timeout_o);
   c_real_result: cover property (@(posedge clk_i) disable iff (rst_i) result_valid_o);
   c_real_start: cover property (@(posedge clk_i) disable iff (rst_i) port_start_o && !dummy_o);
   c_wait_slot: cover property (@(posedge clk_i) disable iff (rst_i) state_r == TPPT_WAIT && slot_end);
endmodule : tppt_timing
`default_nettype wire

// ### tppt_port_model.sv
// Behavioural model of the temperature port that answers each port start
`timescale 1ns/1ns
`default_nettype none
module tppt_port_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [7:0] dly_i,
   output logic            done_o
);
   logic [7:0] cnt_r;
   // Delay zero means the port never completes, which forces a timeout
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         cnt_r  <= rst_i ? 8'h00 : dly_i;
         done_o <= 1'b0;
      end else begin
         cnt_r  <= (cnt_r > 8'h01) ? cnt_r - 8'h01 : 8'h00;
         done_o <= (cnt_r == 8'h01);
      end
   end
endmodule : tppt_port_model
`default_nettype wire

// ### temp_preamble_port_timing_tb.sv
// Testbench of the preamble and port timing block
`timescale 1ns/1ns
`default_nettype none
`include "tppt_defines.svh"
module temp_preamble_port_timing_tb;
   import tppt_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         done, pst, dmy, tmo, rv, ack;
   tppt_wb_req_s req   = '0;
   logic [31:0]  rd, q;
   logic [7:0]   dly   = 8'h00;
   int           bad_count = 0, checks_done = 0, cyc_n = 0, last_n = -1, lim = 0;
   int           n_port, n_dmy, n_tmo, n_res, n_rdm, n_gap;
   always #25 clk_i = ~clk_i;
   tppt_timing #(.UNIT_CYC(16'h0010)) u_tppt_timing (.clk_i(clk_i), .rst_i(rst_i),
      .wb_req_i(req), .wb_dat_o(rd), .wb_ack_o(ack), .port_done_i(done),
      .port_start_o(pst), .dummy_o(dmy), .timeout_o(tmo), .result_valid_o(rv));
   tppt_port_model u_tppt_port_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(pst),
      .dly_i(dly), .done_o(done));
   ////////////////////////////////////////////////////////////////////////////////
   // Outputs are registered, so values seen at an edge are the settled ones
   always @(posedge clk_i) begin
      cyc_n++;
      if (pst === 1'b1) begin
         n_port++;
         n_dmy += (dmy === 1'b1);
         n_gap += (last_n >= 0 && cyc_n - last_n != lim);
         last_n = cyc_n;
      end
      n_tmo += (tmo === 1'b1);
      n_res += (rv === 1'b1);
      n_rdm += (rv === 1'b1 && dmy === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, w, 4'hF, a, d};
      // No cycle count is assumed; only the watchdog ends a hung wait
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rd;
      req <= '0;
   endtask : wb
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   task automatic run(input int pre, input int sel, input int tst, input int d);
      int np;
      np = (pre + 1) * (tst + 1);
      dly <= 8'(d);
      wb(1'b1, `TPPT_ADR_ETC2, 32'(pre * 4 + sel));
      lim = (sel + 1) * 16;
      last_n = -1;
      {n_port, n_dmy, n_tmo, n_res, n_rdm, n_gap} = 192'h0;
      wb(1'b1, `TPPT_ADR_CTRL, 32'(tst * 2 + 1));
      repeat (np * lim + 40) @(posedge clk_i);
      chk("ports", 32'(np), 32'(n_port));
      chk("dummies", 32'(pre * (tst + 1)), 32'(n_dmy));
      chk("gaps", 32'h0, 32'(n_gap));
      chk("timeouts", d ? 32'h0 : 32'(np), 32'(n_tmo));
      chk("results", d ? 32'(tst + 1) : 32'h0, 32'(n_res));
      chk("dummy results", 32'h0, 32'(n_rdm));
      wb(1'b0, `TPPT_ADR_STAT, 32'h0);
      chk("state", 32'h0, {30'h0, q[1:0]});
      // Model sees the start one edge late, then d cycles, then two sync stages
      wb(1'b0, `TPPT_ADR_RES, 32'h0);
      if (d != 0) chk("result", 32'(d + 3), q);
      $display("test pre %0d sel %0d tst %0d dly %0d done", pre, sel, tst, d);
   endtask : run
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `TPPT_ADR_ETC2, 32'h0);
      chk("etc2 reset", 32'h0, q);
      wb(1'b1, `TPPT_ADR_ETC2, 32'hFFFFFFFF);
      wb(1'b0, `TPPT_ADR_ETC2, 32'h0);
      chk("etc2 lanes", 32'h0000FFFF, q);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("test registers done");
      run(0, 0, 0, 5);
      run(7, 3, 1, 5);
      run(3, 1, 0, 0);
      run(2, 2, 1, 4);
      results();
   end
endmodule : temp_preamble_port_timing_tb
`default_nettype wire
